// ==== hw/sfp_device.sv ====
`include "sfp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sfp_device (
	sfp_if.dev                          lnk,
	input  wire logic                   mclk_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   por_i,
	output logic [7:0]                  opcode_o,
	output logic [`SFP_PAGE_BITS-1:0]   page_addr_o,
	output logic [`SFP_BYTE_BITS-1:0]   byte_addr_o,
	output logic                        frame_valid_o,
	output logic                        mode3_o,
	output logic                        standby_o,
	input  wire logic                   resp_en_i,
	input  wire logic [7:0]             resp_byte_i
);
	typedef struct packed {
		logic [1:0]                     cs_s;
		logic [1:0]                     ck_s;
		logic [1:0]                     si_s;
		logic                           cs_d;
		logic                           ck_d;
		logic                           armed;
		logic                           mode3;
		logic [5:0]                     cnt;
		logic [`SFP_FRAME_BITS-1:0]     sh;
		logic [7:0]                     op;
		logic [`SFP_PAGE_BITS-1:0]      pa;
		logic [`SFP_BYTE_BITS-1:0]      ba;
		logic                           fv;
		logic [7:0]                     tx;
		logic                           so;
		logic                           oe;
	} sfp_dev_s;
	sfp_dev_s st_r, st_nxt;
	logic cs_fall, ck_rise, ck_fall, sel, rst;
	always_comb begin
		rst     = sys_rst_i | por_i;
		sel     = ~st_r.cs_s[1];
		cs_fall = st_r.cs_d & ~st_r.cs_s[1];
		ck_rise = ~st_r.ck_d & st_r.ck_s[1];
		ck_fall = st_r.ck_d & ~st_r.ck_s[1];
		st_nxt  = st_r;
		st_nxt.cs_s = {st_r.cs_s[0], lnk.cs_n};
		st_nxt.ck_s = {st_r.ck_s[0], lnk.sclk};
		st_nxt.si_s = {st_r.si_s[0], lnk.si};
		st_nxt.cs_d = st_r.cs_s[1];
		st_nxt.ck_d = st_r.ck_s[1];
		st_nxt.fv   = 1'b0;
		if (cs_fall) begin
			st_nxt.armed = 1'b1;
			st_nxt.mode3 = st_r.ck_s[1];
			st_nxt.cnt   = '0;
		end else if (sel && st_r.armed) begin
			if (ck_rise && st_r.cnt < 6'(`SFP_FRAME_BITS)) begin
				st_nxt.sh  = {st_r.sh[`SFP_FRAME_BITS-2:0], st_r.si_s[1]};
				st_nxt.cnt = st_r.cnt + 6'd1;
				if (st_r.cnt == 6'(`SFP_FRAME_BITS-1)) begin
					st_nxt.op = st_r.sh[`SFP_FRAME_BITS-2:`SFP_ADDR_BITS-1];
					// Reserved bits dropped
					st_nxt.pa = st_r.sh[`SFP_ADDR_BITS-2-`SFP_RSVD_BITS:`SFP_BYTE_BITS-1];
					st_nxt.ba = {st_r.sh[`SFP_BYTE_BITS-2:0], st_r.si_s[1]};
					st_nxt.fv = 1'b1;
					st_nxt.tx = resp_byte_i;
				end
			end
			if (ck_fall && resp_en_i && st_r.cnt >= 6'(`SFP_FRAME_BITS)) begin
				st_nxt.oe = 1'b1;
				st_nxt.so = st_r.tx[7];
				st_nxt.tx = {st_r.tx[6:0], st_r.tx[7]};
			end
		end
		if (!sel) begin
			st_nxt.oe  = 1'b0;
			st_nxt.cnt = '0;
		end
		if (rst) begin
			st_nxt       = '0;
			// Select seen low, so a held select gives no fall
			st_nxt.cs_s  = 2'h0;
			st_nxt.cs_d  = 1'b0;
			st_nxt.ck_s  = 2'h3;
			st_nxt.ck_d  = 1'b1;
			st_nxt.mode3 = 1'b1;
		end
	end
	always_ff @(posedge mclk_i) begin
		st_r <= st_nxt;
	end
	assign lnk.so_o    = st_r.so;
	assign lnk.so_oe   = st_r.oe;
	assign opcode_o    = st_r.op;
	assign page_addr_o = st_r.pa;
	assign byte_addr_o = st_r.ba;
	assign frame_valid_o = st_r.fv;
	assign mode3_o     = st_r.mode3;
	assign standby_o   = ~st_r.armed | st_r.cs_s[1];
endmodule : sfp_device
`default_nettype wire

// ==== hw/sfp_params.svh ====
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH
// Power-up waits in their own units
`define SFP_SUPPLY_TO_SELECT_WAIT_US 70
`define SFP_PROGRAM_ERASE_STARTUP_DELAY_MS 3
`define SFP_CLK_MHZ 200
// Cycle counts: least time rounds up, both are whole at 200 MHz
`define SFP_SUPPLY_TO_SELECT_WAIT_CYC (`SFP_SUPPLY_TO_SELECT_WAIT_US * `SFP_CLK_MHZ)
`define SFP_PROGRAM_ERASE_STARTUP_DELAY_CYC (`SFP_PROGRAM_ERASE_STARTUP_DELAY_MS * 1000 * `SFP_CLK_MHZ)
// Address field layout in 528-byte page mode
`define SFP_PAGE_BITS 12
`define SFP_BYTE_BITS 10
`define SFP_RSVD_BITS 2
`define SFP_ADDR_BITS 24
`define SFP_FRAME_BITS 32
`define SFP_SCLK_HALF 4
`endif

// ==== hw/sfp_pkg.sv ====
package sfp_pkg;
	typedef enum logic [0:0] {
		SFP_MODE0 = 1'b0,
		SFP_MODE3 = 1'b1
	} sfp_mode_e;
	typedef enum logic [1:0] {
		SFP_H_PWRUP = 2'b00,
		SFP_H_IDLE  = 2'b01,
		SFP_H_SHIFT = 2'b10,
		SFP_H_DONE  = 2'b11
	} sfp_hstate_e;
endpackage : sfp_pkg

// ==== hw/sfp_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sfp_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so_o;
	logic so_oe;
	modport dev  (input cs_n, input sclk, input si, output so_o, output so_oe);
	modport host (output cs_n, output sclk, output si, input so_o, input so_oe);
endinterface : sfp_if
`default_nettype wire

// ==== hw/sfp_host.sv ====
`include "sfp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sfp_host #(
	parameter int unsigned SELECT_WAIT_CYC = `SFP_SUPPLY_TO_SELECT_WAIT_CYC,
	parameter int unsigned PE_DELAY_CYC    = `SFP_PROGRAM_ERASE_STARTUP_DELAY_CYC
) (
	sfp_if.host                         lnk,
	input  wire logic                   mclk_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   start_i,
	input  wire logic                   prog_erase_i,
	input  wire logic                   mode3_i,
	input  wire logic [7:0]             opcode_i,
	input  wire logic [`SFP_PAGE_BITS-1:0] page_addr_i,
	input  wire logic [`SFP_BYTE_BITS-1:0] byte_addr_i,
	output logic                        ready_o,
	output logic                        done_o
);
	typedef struct packed {
		sfp_pkg::sfp_hstate_e           state;
		logic [31:0]                    wait_cnt;
		logic                           pe_ok;
		logic [`SFP_FRAME_BITS-1:0]     sh;
		logic [5:0]                     bits;
		logic [2:0]                     half;
		logic                           cs_n;
		logic                           sclk;
		logic                           mode3;
		logic                           done;
	} sfp_host_s;
	sfp_host_s st_r, st_nxt;
	logic may_go;
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (st_r.wait_cnt != 32'hffffffff)
			st_nxt.wait_cnt = st_r.wait_cnt + 32'h1;
		if (st_r.wait_cnt >= PE_DELAY_CYC)
			st_nxt.pe_ok = 1'b1;
		may_go = start_i && (!prog_erase_i || st_r.pe_ok);
		case (st_r.state)
			sfp_pkg::SFP_H_PWRUP: begin
				if (st_r.wait_cnt >= SELECT_WAIT_CYC)
					st_nxt.state = sfp_pkg::SFP_H_IDLE;
			end
			sfp_pkg::SFP_H_IDLE: begin
				if (may_go) begin
					st_nxt.sclk  = mode3_i;
					st_nxt.mode3 = mode3_i;
					st_nxt.cs_n  = 1'b0;
					st_nxt.sh    = {opcode_i, `SFP_RSVD_BITS'(0), page_addr_i, byte_addr_i};
					st_nxt.bits  = '0;
					st_nxt.half  = '0;
					st_nxt.state = sfp_pkg::SFP_H_SHIFT;
				end
			end
			sfp_pkg::SFP_H_SHIFT: begin
				st_nxt.half = st_r.half + 3'd1;
				if (st_r.half == 3'(`SFP_SCLK_HALF - 1)) begin
					st_nxt.half = '0;
					st_nxt.sclk = ~st_r.sclk;
					if (!st_r.sclk) begin
						st_nxt.bits = st_r.bits + 6'd1;
					end else if (st_r.bits != 6'd0) begin
						// Leading mode 3 fall keeps the first bit
						st_nxt.sh = {st_r.sh[`SFP_FRAME_BITS-2:0], 1'b0};
					end
					if (st_r.bits == 6'(`SFP_FRAME_BITS)) begin
						st_nxt.sclk  = st_r.mode3;
						st_nxt.state = sfp_pkg::SFP_H_DONE;
					end
				end
			end
			default: begin
				st_nxt.cs_n  = 1'b1;
				st_nxt.done  = 1'b1;
				st_nxt.state = sfp_pkg::SFP_H_IDLE;
			end
		endcase
		if (sys_rst_i) begin
			st_nxt       = '0;
			st_nxt.state = sfp_pkg::SFP_H_PWRUP;
			st_nxt.cs_n  = 1'b1;
			st_nxt.sclk  = 1'b1;
			st_nxt.mode3 = 1'b1;
		end
	end
	always_ff @(posedge mclk_i) begin
		st_r <= st_nxt;
	end
	assign lnk.cs_n = st_r.cs_n;
	assign lnk.sclk = st_r.sclk;
	assign lnk.si   = st_r.sh[`SFP_FRAME_BITS-1];
	assign ready_o  = (st_r.state == sfp_pkg::SFP_H_IDLE);
	assign done_o   = st_r.done;
endmodule : sfp_host
`default_nettype wire

// ==== sim/sfp_link_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfp_link_asserts (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	input wire logic so_oe
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	a_oe_idle_off: assert property (cs_n [*6] |-> !so_oe)
		else $error("so_oe while deselected");
	a_rst_quiet: assert property ($fell(sys_rst_i) |-> cs_n && !so_oe)
		else $error("busy after reset");
	a_select_wait: assert property ($fell(sys_rst_i) |-> cs_n [*8])
		else $error("select too early");
	a_idle_clk: assert property (cs_n && $past(cs_n) |-> $stable(sclk))
		else $error("clock moved while idle");
	a_clk_held_sel: assert property ($fell(cs_n) |=> $stable(sclk) [*2])
		else $error("idle level not held");
	a_frame_len: assert property ($fell(cs_n) |-> ##[250:270] cs_n)
		else $error("frame not 32 bits");
	a_si_hold: assert property (!cs_n && $rose(sclk) |-> $stable(si))
		else $error("si moved at rise");
	a_no_early_out: assert property ($fell(cs_n) |-> !so_oe [*8])
		else $error("early so_oe");
	c_mode0: cover property ($fell(cs_n) && !sclk);
	c_mode3: cover property ($fell(cs_n) && sclk);
	c_end: cover property ($rose(cs_n));
	c_resp: cover property ($rose(so_oe));
endmodule : sfp_link_asserts
`default_nettype wire

// ==== sim/serial_flash_powerup_frame_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_flash_powerup_frame_tb_top;
	logic        mclk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        por = 1'b0;
	logic        start = 1'b0;
	logic        pe = 1'b0;
	logic        m3 = 1'b1;
	logic [7:0]  op = 8'h00;
	logic [11:0] pg = 12'h000;
	logic [9:0]  ba = 10'h000;
	logic [7:0]  op_o;
	logic [11:0] pg_o;
	logic [9:0]  ba_o;
	logic        fv_o;
	logic        m3_o;
	logic        sb_o;
	logic        done_o;
	logic        rdy;
	logic        rsp_en = 1'b0;
	logic [7:0]  rsp_b = 8'h00;
	int          failures = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          cs_at = 0;
	sfp_if lnk ();
	sfp_host #(.SELECT_WAIT_CYC(20), .PE_DELAY_CYC(50)) sfp_host_i (.lnk(lnk), .mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i), .start_i(start), .prog_erase_i(pe), .mode3_i(m3), .opcode_i(op),
		.page_addr_i(pg), .byte_addr_i(ba), .ready_o(rdy), .done_o(done_o));
	sfp_device sfp_device_i (.lnk(lnk), .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .por_i(por),
		.opcode_o(op_o), .page_addr_o(pg_o), .byte_addr_o(ba_o), .frame_valid_o(fv_o), .mode3_o(m3_o),
		.standby_o(sb_o), .resp_en_i(rsp_en), .resp_byte_i(rsp_b));
	sfp_link_asserts sfp_link_asserts_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cs_n(lnk.cs_n),
		.sclk(lnk.sclk), .si(lnk.si), .so_oe(lnk.so_oe));
	initial forever #2.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) cyc <= sys_rst_i ? 0 : cyc + 1;
	task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic rst();
		sys_rst_i <= 1'b1;
		repeat (12) @(posedge mclk_i);
		cmp("mode3", 12'h001, 12'(m3_o));
		cmp("standby", 12'h001, 12'(sb_o));
		cmp("so_oe", 12'h000, 12'(lnk.so_oe));
		cmp("ready", 12'h000, 12'(rdy));
		sys_rst_i <= 1'b0;
		cs_at = 0;
	endtask : rst
	task automatic frame(input string nm, input logic m, input logic p, input logic [7:0] o,
		input logic [11:0] g, input logic [9:0] b, input logic [11:0] nv, input logic pp, input logic eo);
		int n;
		int seen;
		int oe;
		logic mid_sb;
		logic sob;
		n = 0;
		seen = 0;
		oe = 0;
		mid_sb = 1'b0;
		sob = 1'b0;
		m3 <= m;
		pe <= p;
		op <= o;
		pg <= g;
		ba <= b;
		start <= 1'b1;
		while (n < 400) begin
			@(posedge mclk_i);
			if (lnk.cs_n === 1'b0) start <= 1'b0;
			if (lnk.cs_n === 1'b0 && cs_at == 0) cs_at = cyc;
			if (pp && n == 20) por <= 1'b1;
			if (pp && n == 24) por <= 1'b0;
			if (n == 100) mid_sb = sb_o;
			if (lnk.so_oe === 1'b1 && oe == 0) sob = lnk.so_o;
			if (lnk.so_oe === 1'b1) oe++;
			if (fv_o === 1'b1) seen++;
			n = (done_o === 1'b1) ? 390 : n + 1;
		end
		cmp({nm, " valid"}, nv, 12'(seen));
		cmp({nm, " so_oe"}, 12'(eo), 12'(oe != 0));
		cmp({nm, " standby"}, 12'(nv == 12'h000), 12'(mid_sb));
		if (eo) cmp({nm, " so"}, 12'(rsp_b[7]), 12'(sob));
		if (nv == 12'h001) begin
			cmp({nm, " opcode"}, 12'(o), 12'(op_o));
			cmp({nm, " page"}, g, pg_o);
			cmp({nm, " byte"}, 12'(b), 12'(ba_o));
			cmp({nm, " mode"}, 12'(m), 12'(m3_o));
		end else begin
			cmp({nm, " mode"}, 12'h001, 12'(m3_o));
		end
		$display("test %s done", nm);
	endtask : frame
	task automatic t_first_pe();
		rst();
		frame("pe first", 1'b1, 1'b1, 8'h82, 12'h000, 10'h000, 12'h001, 1'b0, 1'b0);
		cmp("pe wait", 12'h001, 12'(cs_at >= 50));
	endtask : t_first_pe
	task automatic t_modes();
		frame("mode0", 1'b0, 1'b0, 8'hd2, 12'hfff, 10'h3ff, 12'h001, 1'b0, 1'b0);
		rst();
		frame("mode0 rst", 1'b0, 1'b0, 8'h55, 12'ha5a, 10'h2a5, 12'h001, 1'b0, 1'b0);
		cmp("select wait", 12'h001, 12'(cs_at >= 20));
	endtask : t_modes
	task automatic t_por();
		por <= 1'b1;
		frame("por", 1'b0, 1'b0, 8'h0b, 12'h123, 10'h321, 12'h000, 1'b0, 1'b0);
		por <= 1'b0;
		repeat (4) @(posedge mclk_i);
		cmp("por mode3", 12'h001, 12'(m3_o));
		frame("after por", 1'b0, 1'b0, 8'hd4, 12'h800, 10'h001, 12'h001, 1'b0, 1'b0);
	endtask : t_por
	task automatic t_late_sel();
		frame("late sel", 1'b0, 1'b0, 8'h3c, 12'h5a5, 10'h155, 12'h000, 1'b1, 1'b0);
	endtask : t_late_sel
	task automatic t_resp();
		rsp_en <= 1'b1;
		rsp_b <= 8'h9c;
		frame("resp", 1'b0, 1'b0, 8'h0b, 12'h0f0, 10'h30f, 12'h001, 1'b0, 1'b1);
		rsp_en <= 1'b0;
	endtask : t_resp
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	initial begin
		t_first_pe();
		t_modes();
		t_por();
		t_late_sel();
		t_resp();
		test_done();
	end
	initial begin
		repeat (5000) @(posedge mclk_i);
		failures++;
		test_done();
	end
endmodule : serial_flash_powerup_frame_tb_top
`default_nettype wire
